// *** hdl/gxi_pins.sv ***
// Nonmaskable, external interrupt and general-purpose pin block
// Functional notes
// - Nonmaskable interrupt fires on rising input edge
// - Shared pins reset as inputs, drivers off
// - Enable bits 7:4 make pins interrupt sources
// - Interrupt pins edge-detected, one event per transition
// - Per-pin polarity bits in four-bit field
// - Pins ten-fifteen: gpio or bus, none default
`timescale 1ns/1ps
`default_nettype none
module gxi_pins (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    // Dedicated nonmaskable input and interrupt line
    input  wire logic        nmi_i,
    output logic             irq_o,
    // Shared pins, index 0 is gpio four
    input  wire logic [3:0]  sh_in_i,
    output logic [3:0]       sh_out_o,
    output logic [3:0]       sh_oe_o,
    // Muxed pins, index 0 is pin ten
    input  wire logic [5:0]  mx_in_i,
    output logic [5:0]       mx_out_o,
    output logic [5:0]       mx_oe_o,
    // Bus-interface side of muxed pins
    input  wire logic [5:0]  bus_out_i,
    input  wire logic [5:0]  bus_oe_i,
    output logic [5:0]       bus_in_o
);
    logic [1:0]  rst_sync_ff;   // Reset release chain
    logic        rst_n;         // Synchronised reset
    logic [7:0]  irq_en_ff;     // Interrupt enables
    logic [3:0]  pol_ff;        // Edge polarity per pin
    logic [9:0]  dir_ff;        // 1 drives the pin
    logic [9:0]  dout_ff;       // Output values
    logic [13:0] func_ff;       // Muxed pin function
    logic [7:0]  stat_ff;       // Sticky interrupt status
    logic [31:0] rdata_ff;
    logic        irq_ff;
    logic [3:0]  sh_out_ff, sh_oe_ff;
    logic [5:0]  mx_out_ff, mx_oe_ff, bus_in_ff;

    // Release reset through two flip-flops
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Address decode
    wire hit_en   = addr_i == gxi_pkg::OFF_IRQ_EN;
    wire hit_pol  = addr_i == gxi_pkg::OFF_POL;
    wire hit_dir  = addr_i == gxi_pkg::OFF_DIR;
    wire hit_dout = addr_i == gxi_pkg::OFF_DOUT;
    wire hit_din  = addr_i == gxi_pkg::OFF_DIN;
    wire hit_func = addr_i == gxi_pkg::OFF_FUNC;
    wire hit_stat = addr_i == gxi_pkg::OFF_STAT;
    wire hit_clr  = addr_i == gxi_pkg::OFF_CLR;

    // Ext enables; the nonmaskable bit cannot be masked off
    wire [3:0] ext_en = irq_en_ff[gxi_pkg::BIT_EXT_HI:gxi_pkg::BIT_EXT_LO];
    wire [7:0] en_view = irq_en_ff | (8'h01 << gxi_pkg::BIT_NMI);

    // Edge detectors: slot 0 nonmaskable, slots 1..4 shared pins
    wire [4:0] ev;
    gxi_edge_if eif [gxi_pkg::N_EV] ();
    assign eif[0].level = nmi_i;
    assign eif[0].pol   = 1'b0;
    assign ev[0]        = eif[0].pulse;
    for (genvar k = 0; k < gxi_pkg::N_SH; k++) begin : g_ext
        assign eif[k+1].level = sh_in_i[k];
        assign eif[k+1].pol   = pol_ff[k];
        assign ev[k+1]        = eif[k+1].pulse;
    end
    for (genvar k = 0; k < gxi_pkg::N_EV; k++) begin : g_det
        gxi_edge_det u_det (
            .clk_i   (clk_i),
            .rst_n_i (rst_n),
            .e       (eif[k])
        );
    end
    wire [3:0] ext_ev = ev[4:1];

    // Status: new events win over a clear in the same cycle
    wire [7:0] ev_map  = {ext_ev, 2'h0, ev[0], 1'b0};
    wire [7:0] clr_msk = (wr_i && hit_clr) ? wdata_i[7:0] : 8'h00;
    wire [7:0] nxt_stat = (stat_ff & ~clr_msk) | ev_map;
    wire       nxt_irq  = |(nxt_stat & en_view);

    // Pin drive: an interrupt pin never drives, as it is input only
    wire [3:0] nxt_sh_oe  = dir_ff[3:0] & ~ext_en;
    wire [5:0] gp_en      = func_ff[gxi_pkg::FUNC_GP_LO +: gxi_pkg::N_MX];
    wire [5:0] bus_en     = func_ff[gxi_pkg::FUNC_BUS_LO +: gxi_pkg::N_MX];
    // Bus function wins where both are set; neither leaves the pin idle
    wire [5:0] nxt_mx_oe  = (bus_en & bus_oe_i) | (~bus_en & gp_en & dir_ff[9:4]);
    wire [5:0] nxt_mx_out = (bus_en & bus_out_i) | (~bus_en & dout_ff[9:4]);
    wire [5:0] nxt_bus_in = bus_en & mx_in_i;

    // Read selection
    wire [31:0] nxt_rdata =
        hit_en   ? {24'h0, en_view}                         :
        hit_pol  ? {28'h0, pol_ff}                          :
        hit_dir  ? {22'h0, dir_ff}                          :
        hit_dout ? {22'h0, dout_ff}                         :
        hit_din  ? {22'h0, mx_in_i, sh_in_i}                :
        hit_func ? {18'h0, func_ff}                         :
        hit_stat ? {24'h0, stat_ff}                         :
                   gxi_pkg::RD_NONE;

    // Software-written registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_ff <= gxi_pkg::RST_IRQ_EN;
            pol_ff    <= gxi_pkg::RST_POL;
            dir_ff    <= gxi_pkg::RST_DIR;
            dout_ff   <= gxi_pkg::RST_DOUT;
            func_ff   <= gxi_pkg::RST_FUNC;
        end else if (wr_i) begin
            if (hit_en)   irq_en_ff <= wdata_i[7:0] & 8'hF0;
            if (hit_pol)  pol_ff    <= wdata_i[3:0];
            if (hit_dir)  dir_ff    <= wdata_i[9:0];
            if (hit_dout) dout_ff   <= wdata_i[9:0];
            if (hit_func) func_ff   <= wdata_i[13:0];
        end
    end

    // Status, read data and registered outputs
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            stat_ff   <= 8'h00;
            irq_ff    <= 1'b0;
            rdata_ff  <= gxi_pkg::RD_NONE;
            sh_oe_ff  <= 4'h0;
            sh_out_ff <= 4'h0;
            mx_oe_ff  <= 6'h00;
            mx_out_ff <= 6'h00;
            bus_in_ff <= 6'h00;
        end else begin
            stat_ff   <= nxt_stat;
            irq_ff    <= nxt_irq;
            rdata_ff  <= rd_i ? nxt_rdata : gxi_pkg::RD_NONE;
            sh_oe_ff  <= nxt_sh_oe;
            sh_out_ff <= dout_ff[3:0];
            mx_oe_ff  <= nxt_mx_oe;
            mx_out_ff <= nxt_mx_out;
            bus_in_ff <= nxt_bus_in;
        end
    end

    assign rdata_o  = rdata_ff;
    assign irq_o    = irq_ff;
    assign sh_oe_o  = sh_oe_ff;
    assign sh_out_o = sh_out_ff;
    assign mx_oe_o  = mx_oe_ff;
    assign mx_out_o = mx_out_ff;
    assign bus_in_o = bus_in_ff;

    // Checks; they sleep while the synchronised reset is low
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    // Nonmaskable steps: input rises, pulse next cycle, then status and line
    sequence s_nmi_rise;
        $rose(nmi_i) && $past(rst_n, 2);
    endsequence
    sequence s_nmi_seen;
        ##1 ev[0] ##1 stat_ff[gxi_pkg::BIT_NMI] && irq_o;
    endsequence

    // A clean rising edge reaches status and the line two cycles on
    chk_nmi_rise: assert property (s_nmi_rise |-> s_nmi_seen)
        else $error("nmi rise not latched");
    // A nonmaskable pulse only ever follows a low-to-high step
    chk_nmi_level: assert property (ev[0] |-> $past(nmi_i) && !$past(nmi_i, 2))
        else $error("nmi event without rising edge");
    // Shared drivers stay off across the release of reset
    chk_reset_inputs: assert property ($rose(rst_n) |-> sh_oe_o == 4'h0 ##1 sh_oe_o == 4'h0)
        else $error("shared pin drives after reset");
    // An interrupt-enabled pin is input only
    chk_irq_pin_input: assert property (1'b1 |=> (sh_oe_o & $past(ext_en)) == 4'h0)
        else $error("interrupt pin driven");
    // One transition gives one event, never a held level
    chk_one_event: assert property (ext_ev != 4'h0 |=> (ext_ev & $past(ext_ev)) == 4'h0)
        else $error("event longer than one cycle");
    // Polarity zero on the lowest pin catches a rise
    chk_pol_rise: assert property (!pol_ff[0] && $rose(sh_in_i[0]) && $past(rst_n, 2)
            && $stable(pol_ff[0]) |=> ext_ev[0])
        else $error("rising edge missed");
    // Polarity one on the lowest pin catches a fall
    chk_pol_fall: assert property (pol_ff[0] && $fell(sh_in_i[0]) && $past(rst_n, 2)
            && $stable(pol_ff[0]) |=> ext_ev[0])
        else $error("falling edge missed");
    // No function selected leaves muxed pins idle
    chk_mux_idle: assert property (func_ff == 14'h0000 |=> mx_oe_o == 6'h00 && bus_in_o == 6'h00)
        else $error("muxed pin active with no function");
    // Where the bus function is chosen, the bus side owns the driver
    chk_bus_wins: assert property (bus_en != 6'h00
            |=> (mx_oe_o & $past(bus_en)) == ($past(bus_oe_i) & $past(bus_en)))
        else $error("bus function lost its pin");
    // Enabled status holds the line high next cycle
    chk_irq_level: assert property (((stat_ff & en_view) != 8'h00) && !(wr_i && hit_clr)
            |=> irq_o)
        else $error("interrupt line low with enabled status");
    // Read data stand for one cycle only, zero otherwise
    chk_read_idle: assert property (!$past(rd_i) |-> rdata_o == gxi_pkg::RD_NONE)
        else $error("read data outside a read cycle");
    // A clear with no event in flight empties the bits it names
    chk_stat_clear: assert property (wr_i && hit_clr && ev_map == 8'h00
            |=> (stat_ff & $past(wdata_i[7:0])) == 8'h00)
        else $error("status bit survives its clear");
    // A new event is never lost, even beside a clear
    chk_set_wins: assert property (ev_map != 8'h00
            |=> (stat_ff & $past(ev_map)) == $past(ev_map))
        else $error("status event lost");
endmodule : gxi_pins
`default_nettype wire

// *** include/gxi_pkg.sv ***
// Constants for the interrupt and general-purpose pin block
package gxi_pkg;
    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_IRQ_EN = 8'h00;
    localparam logic [7:0] OFF_POL    = 8'h04;
    localparam logic [7:0] OFF_DIR    = 8'h08;
    localparam logic [7:0] OFF_DOUT   = 8'h0C;
    localparam logic [7:0] OFF_DIN    = 8'h10;
    localparam logic [7:0] OFF_FUNC   = 8'h14;
    localparam logic [7:0] OFF_STAT   = 8'h18;
    localparam logic [7:0] OFF_CLR    = 8'h1C;
    // Pin counts
    localparam int N_SH  = 4;   // Shared pins (gpio four..seven)
    localparam int N_MX  = 6;   // Bus-muxed pins (ten..fifteen)
    localparam int N_GP  = N_SH + N_MX;
    localparam int N_EV  = N_SH + 1;
    // Interrupt layout: enable, status and clear share it
    localparam int BIT_NMI    = 1;
    localparam int BIT_EXT_LO = 4;
    localparam int BIT_EXT_HI = 7;
    localparam int IRQ_W      = 8;
    // Function register layout
    localparam int FUNC_GP_LO  = 0;
    localparam int FUNC_BUS_LO = 8;
    localparam int FUNC_W      = 14;
    // Reset values
    localparam logic [7:0]  RST_IRQ_EN = 8'h00;
    localparam logic [3:0]  RST_POL    = 4'h0;
    localparam logic [9:0]  RST_DIR    = 10'h000;
    localparam logic [9:0]  RST_DOUT   = 10'h000;
    localparam logic [13:0] RST_FUNC   = 14'h0000;
    localparam logic [31:0] RD_NONE    = 32'h0000_0000;
endpackage : gxi_pkg

// *** include/gxi_edge_if.sv ***
// Bundle between the top and one edge detector
`timescale 1ns/1ps
`default_nettype none
interface gxi_edge_if;
    logic level;   // Sampled pin level
    logic pol;     // 0 rising, 1 falling
    logic pulse;   // One-cycle event
    modport det (input level, input pol, output pulse);
    modport own (output level, output pol, input pulse);
endinterface : gxi_edge_if
`default_nettype wire

// *** hdl/gxi_edge_det.sv ***
// Single-pin edge detector with selectable polarity
`timescale 1ns/1ps
`default_nettype none
module gxi_edge_det (
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    gxi_edge_if.det     e
);
    logic prev_ff;    // Level seen last cycle
    logic armed_ff;   // Low for the first cycle after reset
    logic pulse_ff;   // Registered event
    logic nxt_pulse;

    // Compare with last level; polarity picks the direction
    assign nxt_pulse = armed_ff & (e.pol ? (prev_ff & ~e.level)
                                         : (~prev_ff & e.level));
    assign e.pulse   = pulse_ff;

    // History, arming and pulse; arming hides a level present at reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_ff  <= 1'b0;
            armed_ff <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            prev_ff  <= e.level;
            armed_ff <= 1'b1;
            pulse_ff <= nxt_pulse;
        end
    end
endmodule : gxi_edge_det
`default_nettype wire

// *** tb/gxi_src_model.sv ***
// Board-side model: interrupt sources and the pulled-down shared pins
`timescale 1ns/1ps
`default_nettype none
module gxi_src_model (
    input  wire logic       clk_i,
    input  wire logic [3:0] sh_out_i,
    input  wire logic [3:0] sh_oe_i,
    output logic            nmi_o,
    output logic [3:0]      sh_pin_o
);
    logic [3:0] ext_lvl;  // Level the board puts on each shared pin
    // Pull-downs keep every line low until a source drives it
    initial begin
        nmi_o   = 1'b0;
        ext_lvl = 4'h0;
    end
    // Wire level: the device wins while its driver is on
    assign sh_pin_o = (sh_oe_i & sh_out_i) | (~sh_oe_i & ext_lvl);
    // Sources only move just after a rising edge
    task automatic set_nmi(input logic v);
        @(posedge clk_i);
        nmi_o <= v;
    endtask : set_nmi
    task automatic set_pin(input int i, input logic v);
        @(posedge clk_i);
        ext_lvl[i] <= v;
    endtask : set_pin
endmodule : gxi_src_model
`default_nettype wire

// *** tb/gxi_pins_test.sv ***
// Self-checking bench for the interrupt and general-purpose pin block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module gxi_pins_test;
    logic        clk;        // 50 MHz clock
    logic        rst_b;      // Active-low reset
    logic [7:0]  addr;       // Register address
    logic [31:0] wdata;      // Write data
    logic        wr;         // Write strobe
    logic        rd;         // Read strobe
    logic [31:0] rdata;      // Read data
    logic        nmi;        // Nonmaskable source
    logic        irq;        // Interrupt line
    logic [3:0]  sh_pin;     // Resolved shared pin levels
    logic [3:0]  sh_out;     // Shared pin values
    logic [3:0]  sh_oe;      // Shared pin enables
    logic [5:0]  mx_in;      // Muxed pin levels from the board
    logic [5:0]  mx_out;     // Muxed pin values
    logic [5:0]  mx_oe;      // Muxed pin enables
    logic [5:0]  bus_out;    // Bus side values
    logic [5:0]  bus_oe;     // Bus side enables
    logic [5:0]  bus_in;     // Pin levels passed to the bus side
    int          errors;     // Mismatch count
    int          tests_run;  // Comparison count
    gxi_pins u_dut (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .nmi_i(nmi), .irq_o(irq), .sh_in_i(sh_pin),
        .sh_out_o(sh_out), .sh_oe_o(sh_oe), .mx_in_i(mx_in), .mx_out_o(mx_out),
        .mx_oe_o(mx_oe), .bus_out_i(bus_out), .bus_oe_i(bus_oe), .bus_in_o(bus_in));
    gxi_src_model u_src (.clk_i(clk), .sh_out_i(sh_out), .sh_oe_i(sh_oe), .nmi_o(nmi),
        .sh_pin_o(sh_pin));
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Counts, verdict and the end of the run
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    // One-cycle write; one idle edge follows so strobes never collide
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg
    // Read, then judge the data in the one cycle they stand
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 `CHK(rdata, exp)
    endtask : rd_chk
    // Let the two-stage event path settle
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask : settle
    // Reset values and an unmapped read
    task automatic t_reset();
        `CHK(sh_oe, 4'h0)
        `CHK(mx_oe, 6'h00)
        `CHK(bus_in, 6'h00)
        rd_chk(gxi_pkg::OFF_IRQ_EN, 32'h0000_0002);
        rd_chk(gxi_pkg::OFF_POL, 32'h0000_0000);
        rd_chk(gxi_pkg::OFF_DIR, 32'h0000_0000);
        rd_chk(gxi_pkg::OFF_FUNC, 32'h0000_0000);
        rd_chk(8'h20, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset
    // Rising edge fires once; held level and falling edge do not
    task automatic t_nmi();
        u_src.set_nmi(1'b1);
        settle();
        `CHK(irq, 1'b1)
        rd_chk(gxi_pkg::OFF_STAT, 32'h0000_0002);
        wr_reg(gxi_pkg::OFF_CLR, 32'h0000_0002);
        settle();
        `CHK(irq, 1'b0)
        u_src.set_nmi(1'b0);
        settle();
        rd_chk(gxi_pkg::OFF_STAT, 32'h0000_0000);
        $display("test nmi done");
    endtask : t_nmi
    // Every pin in both polarities, then a disabled pin
    task automatic t_ext();
        for (int i = 0; i < 4; i++) begin
            for (int p = 0; p < 2; p++) begin
                wr_reg(gxi_pkg::OFF_POL, (p == 1) ? (32'h1 << i) : 32'h0);
                wr_reg(gxi_pkg::OFF_IRQ_EN, 32'h10 << i);
                u_src.set_pin(i, p[0]);
                settle();
                wr_reg(gxi_pkg::OFF_CLR, 32'h0000_00FF);
                u_src.set_pin(i, ~p[0]);
                settle();
                `CHK(irq, 1'b1)
                rd_chk(gxi_pkg::OFF_STAT, 32'h10 << i);
                wr_reg(gxi_pkg::OFF_CLR, 32'h0000_00FF);
                u_src.set_pin(i, p[0]);
                settle();
                `CHK(irq, 1'b0)
                rd_chk(gxi_pkg::OFF_STAT, 32'h0000_0000);
                u_src.set_pin(i, 1'b0);
            end
        end
        wr_reg(gxi_pkg::OFF_POL, 32'h0000_0000);
        wr_reg(gxi_pkg::OFF_IRQ_EN, 32'h0000_0000);
        settle();
        wr_reg(gxi_pkg::OFF_CLR, 32'h0000_00FF);
        u_src.set_pin(0, 1'b1);
        settle();
        `CHK(irq, 1'b0)
        rd_chk(gxi_pkg::OFF_STAT, 32'h0000_0010);
        $display("test ext done");
    endtask : t_ext
    // Shared pins as outputs, then muxed pins as gpio and as bus
    task automatic t_pins();
        u_src.set_pin(0, 1'b0);
        wr_reg(gxi_pkg::OFF_DIR, 32'h0000_000F);
        wr_reg(gxi_pkg::OFF_DOUT, 32'h0000_000A);
        settle();
        `CHK(sh_oe, 4'hF)
        `CHK(sh_out, 4'hA)
        rd_chk(gxi_pkg::OFF_DIN, 32'h0000_02AA);
        wr_reg(gxi_pkg::OFF_IRQ_EN, 32'h0000_0010);
        settle();
        `CHK(sh_oe, 4'hE)
        `CHK(irq, 1'b1)
        rd_chk(gxi_pkg::OFF_STAT, 32'h0000_00B0);
        wr_reg(gxi_pkg::OFF_FUNC, 32'h0000_003F);
        wr_reg(gxi_pkg::OFF_DIR, 32'h0000_03F0);
        wr_reg(gxi_pkg::OFF_DOUT, 32'h0000_0150);
        settle();
        `CHK(mx_oe, 6'h3F)
        `CHK(mx_out, 6'h15)
        `CHK(bus_in, 6'h00)
        wr_reg(gxi_pkg::OFF_FUNC, 32'h0000_3F00);
        settle();
        `CHK(mx_oe, 6'h33)
        `CHK(mx_out, 6'h0C)
        `CHK(bus_in, 6'h2A)
        $display("test pins done");
    endtask : t_pins
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end
    // Main sequence
    initial begin
        errors    = 0;
        tests_run = 0;
        rst_b     = 1'b0;
        addr      = 8'h00;
        wdata     = 32'h0000_0000;
        wr        = 1'b0;
        rd        = 1'b0;
        mx_in     = 6'h2A;
        bus_out   = 6'h0C;
        bus_oe    = 6'h33;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        t_reset();
        t_nmi();
        t_ext();
        t_pins();
        give_verdict();
    end
endmodule : gxi_pins_test
`default_nettype wire
